/* verilog/adcc_top.sv */
`timescale 1ns/10ps
// Operation
// - Left-justify bit selects result alignment
// - Alignment change applies at once
// - Channel change waits for conversion end
// - Codes 0-7 single, 30 bandgap, 31 ground
// - Codes 8-29 differential pairs, 8-15 with gain
// - Enable bit turns converter on/off
// - Clearing enable aborts running conversion
// - First conversion 25 cycles, others 13
// - Start bit reads one while busy
// - Writing zero to start does nothing
// - Auto trigger starts on trigger rising edge
// - Flag sets when result is updated
// - Interrupt when flag, enable, global enable
// - Interrupt acknowledge clears flag
// - Writing one clears flag, zero keeps
// - Prescaler divides by 2 up to 128
// - Free running source gives no trigger
// - Low byte read locks result until high
module adcc_top import adcc_pkg::*; (
	// Clock, reset and enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Trigger sources and processor
	input wire logic [7:1] trig_in,
	input wire logic global_irq_en,
	input wire logic irq_ack,
	output logic irq,
	// Converter core and multiplexer
	input wire logic [RES_W-1:0] sar_result,
	output logic conv_busy,
	output logic conv_init,
	output adcc_src_t mux_src,
	output logic [2:0] mux_pos,
	output logic [2:0] mux_neg,
	output adcc_gain_t mux_gain
);

	typedef enum {ST_IDLE, ST_CONV} adcc_state_t;

	adcc_state_t state;
	adcc_state_t next_state;
	logic left_justify;
	logic [4:0] chan_code;
	logic conv_en;
	logic auto_trig;
	logic flag;
	logic irq_en;
	logic [2:0] presc_sel;
	logic [2:0] trig_sel;
	logic first_pending;
	logic trig_prev;
	logic [4:0] tick_cnt;
	logic [4:0] conv_len;
	adcc_chan_t active_chan;

	adcc_core_if core ();

	// ****************************************************************
	// APB decode
	// ****************************************************************
	wire logic acc = psel & penable & clk_en;
	wire logic setup = psel & !penable & clk_en;
	wire logic wr = acc & pwrite;
	wire logic rd = acc & !pwrite;
	wire logic hit_chan = paddr == OFS_CHAN;
	wire logic hit_ctrl = paddr == OFS_CTRL;
	wire logic hit_rlo = paddr == OFS_RLO;
	wire logic hit_rhi = paddr == OFS_RHI;
	wire logic hit_trig = paddr == OFS_TRIG;
	wire logic mapped = hit_chan | hit_ctrl | hit_rlo | hit_rhi | hit_trig;
	wire logic wr_chan = wr & hit_chan;
	wire logic wr_ctrl = wr & hit_ctrl;
	wire logic wr_trig = wr & hit_trig;

	assign pready = clk_en;
	assign pslverr = psel & penable & !mapped;

	// ****************************************************************
	// Conversion control
	// ****************************************************************
	wire logic busy = state == ST_CONV;
	wire logic new_en = wr_ctrl ? pwdata[BIT_EN] : conv_en;
	wire logic en_rise = new_en & !conv_en;
	wire logic wr_start = wr_ctrl & pwdata[BIT_SC];
	wire logic [7:0] trig_vec = {trig_in, 1'b0};
	wire logic sel_trig = trig_vec[trig_sel];
	wire logic trig_edge = auto_trig & sel_trig & !trig_prev;
	wire logic done = busy & core.tick & (tick_cnt == conv_len - 5'h01);
	wire logic free_relaunch = done & auto_trig & (trig_sel == TS_FREE);
	wire logic can_start = !busy | done;
	wire logic launch = new_en & can_start & (wr_start | trig_edge | free_relaunch);
	wire logic launch_first = first_pending | en_rise;
	wire logic flag_set = done & core.res_taken;
	wire logic flag_clr = (wr_ctrl & pwdata[BIT_FLAG]) | irq_ack;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (launch) begin
					next_state = ST_CONV;
				end
			end
			ST_CONV: begin
				if (!new_en) begin
					next_state = ST_IDLE;
				end else if (done && !launch) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (!new_en) begin
			next_state = ST_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			first_pending <= 1'b0;
			trig_prev <= 1'b0;
			tick_cnt <= 5'h00;
			conv_len <= NORMAL_CYCLES;
		end else if (clk_en) begin
			state <= next_state;
			trig_prev <= sel_trig;
			first_pending <= launch ? 1'b0 : (first_pending | en_rise);
			if (launch) begin
				tick_cnt <= 5'h00;
				conv_len <= launch_first ? FIRST_CYCLES : NORMAL_CYCLES;
			end else if (busy && core.tick) begin
				tick_cnt <= tick_cnt + 5'h01;
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_justify <= 1'b0;
			chan_code <= RST_CODE;
			conv_en <= 1'b0;
			auto_trig <= 1'b0;
			irq_en <= 1'b0;
			presc_sel <= RST_PS;
			trig_sel <= RST_TS;
			flag <= 1'b0;
		end else if (clk_en) begin
			if (wr_chan) begin
				left_justify <= pwdata[BIT_LJ];
				chan_code <= pwdata[CSEL_LSB+:5];
			end
			if (wr_ctrl) begin
				conv_en <= pwdata[BIT_EN];
				auto_trig <= pwdata[BIT_ATE];
				irq_en <= pwdata[BIT_IE];
				presc_sel <= pwdata[PS_LSB+:3];
			end
			if (wr_trig) begin
				trig_sel <= pwdata[TS_LSB+:3];
			end
			flag <= flag_set | (flag & !flag_clr);
		end
	end

	// Selection is held for the whole conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_chan <= '{src: SRC_SINGLE, pos: 3'h0, neg: 3'h0, gain: GAIN_1X};
		end else if (clk_en && (!busy || done)) begin
			active_chan <= adcc_decode(chan_code);
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	wire logic [7:0] chan_rd = {2'b00, left_justify, chan_code};
	wire logic [7:0] ctrl_rd = {conv_en, busy, auto_trig, flag, irq_en, presc_sel};
	wire logic [7:0] trig_rd = {trig_sel, 5'h00};
	wire logic [7:0] rd_mux = hit_chan ? chan_rd :
		hit_ctrl ? ctrl_rd :
		hit_rlo ? core.low_byte :
		hit_rhi ? core.high_byte :
		hit_trig ? trig_rd : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			prdata <= {24'h00_0000, rd_mux};
		end
	end

	// ****************************************************************
	// Submodules and outputs
	// ****************************************************************
	assign core.presc_sel = presc_sel;
	assign core.presc_run = conv_en;
	assign core.res_load = done;
	assign core.res_data = sar_result;
	assign core.left_justify = left_justify;
	assign core.rd_low = rd & hit_rlo;
	assign core.rd_high = rd & hit_rhi;

	adcc_prescaler u_presc (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.bus(core.presc)
	);

	adcc_result_latch u_latch (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.bus(core.rlatch)
	);

	assign irq = flag & irq_en & global_irq_en;
	assign conv_busy = busy;
	assign conv_init = busy & (conv_len == FIRST_CYCLES);
	assign mux_src = active_chan.src;
	assign mux_pos = active_chan.pos;
	assign mux_neg = active_chan.neg;
	assign mux_gain = active_chan.gain;

	// ****************************************************************
	// Checks
	// ****************************************************************
	logic [4:0] chk_ticks;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_ticks <= 5'h00;
		end else if (clk_en) begin
			chk_ticks <= launch ? 5'h00 : chk_ticks + {4'h0, busy & core.tick};
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_LEN: assert property (done |-> chk_ticks + 5'h01 == conv_len)
		else $error("conversion length wrong");
	AST_FIRST: assert property (launch && en_rise |=> conv_len == FIRST_CYCLES)
		else $error("first conversion not long");
	AST_START: assert property (wr_start && new_en && !busy |=> busy && ctrl_rd[BIT_SC])
		else $error("start write did not make busy");
	AST_ABORT: assert property (wr_ctrl && !pwdata[BIT_EN] |=> !busy)
		else $error("disable did not abort");
	AST_ZERO_START: assert property (wr_ctrl && !pwdata[BIT_SC] && !busy && !trig_edge
		|=> !busy)
		else $error("zero start write started conversion");
	AST_HOLD: assert property (busy && $past(busy) && !$past(done) |-> $stable(active_chan))
		else $error("selection changed mid conversion");
	AST_FLAG: assert property (flag_set |=> flag)
		else $error("flag not set at completion");
	AST_ACK: assert property (irq_ack && clk_en && !flag_set |=> !flag)
		else $error("acknowledge did not clear flag");
	AST_W0: assert property (clk_en && flag && !flag_clr |=> flag)
		else $error("flag lost without clear");
	AST_IRQ: assert property (irq |-> flag && irq_en && global_irq_en)
		else $error("interrupt without cause");
	AST_ALIGN: assert property (left_justify |-> core.low_byte[5:0] == 6'h00)
		else $error("left aligned low bits not zero");
	AST_FREE: assert property (clk_en && $changed(trig_sel) && trig_sel == TS_FREE
		&& !busy && !wr_start |=> !busy)
		else $error("free running select caused trigger");

	COV_FIRST: cover property (done && conv_len == FIRST_CYCLES);
	COV_FREE: cover property (free_relaunch ##1 busy);
	COV_LOCK: cover property (done && !core.res_taken);
	COV_ABORT: cover property (busy && wr_ctrl && !pwdata[BIT_EN]);

endmodule : adcc_top

/* inc/adcc_pkg.sv */
package adcc_pkg;

	// ****************************************************************
	// Register map and field layout
	// ****************************************************************
	localparam int APB_AW = 8;
	localparam logic [7:0] OFS_CHAN = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_RLO = 8'h08;
	localparam logic [7:0] OFS_RHI = 8'h0c;
	localparam logic [7:0] OFS_TRIG = 8'h10;
	localparam int BIT_LJ = 5;
	localparam int CSEL_LSB = 0;
	localparam int BIT_EN = 7;
	localparam int BIT_SC = 6;
	localparam int BIT_ATE = 5;
	localparam int BIT_FLAG = 4;
	localparam int BIT_IE = 3;
	localparam int PS_LSB = 0;
	localparam int TS_LSB = 5;

	// ****************************************************************
	// Reset values and counts
	// ****************************************************************
	localparam logic [4:0] RST_CODE = 5'h00;
	localparam logic [2:0] RST_PS = 3'h0;
	localparam logic [2:0] RST_TS = 3'h0;
	localparam logic [2:0] TS_FREE = 3'h0;
	localparam logic [4:0] FIRST_CYCLES = 5'h19;
	localparam logic [4:0] NORMAL_CYCLES = 5'h0d;
	localparam int RES_W = 10;

	// ****************************************************************
	// Channel decode
	// ****************************************************************
	localparam logic [4:0] CODE_SE_MAX = 5'h07;
	localparam logic [4:0] CODE_BANDGAP = 5'h1e;
	localparam logic [4:0] CODE_GND = 5'h1f;

	typedef enum logic [1:0] {SRC_SINGLE, SRC_DIFF, SRC_BANDGAP, SRC_GND} adcc_src_t;
	typedef enum logic [1:0] {GAIN_1X, GAIN_10X, GAIN_200X} adcc_gain_t;
	typedef struct packed {
		adcc_src_t src;
		logic [2:0] pos;
		logic [2:0] neg;
		adcc_gain_t gain;
	} adcc_chan_t;

	function automatic adcc_chan_t adcc_decode(input logic [4:0] c);
		adcc_chan_t r;
		r = '{src: SRC_DIFF, pos: c[2:0], neg: 3'h0, gain: GAIN_1X};
		if (c <= CODE_SE_MAX) begin
			r.src = SRC_SINGLE;
		end else if (c == CODE_BANDGAP) begin
			r.src = SRC_BANDGAP;
			r.pos = 3'h0;
		end else if (c == CODE_GND) begin
			r.src = SRC_GND;
			r.pos = 3'h0;
		end else if (c[4:3] == 2'b01) begin
			r.pos = {1'b0, c[2], c[0]};
			r.neg = {1'b0, c[2], 1'b0};
			r.gain = c[1] ? GAIN_200X : GAIN_10X;
		end else begin
			r.neg = c[3] ? 3'h2 : 3'h1;
		end
		return r;
	endfunction : adcc_decode

	// Last count of the divider, divisor minus one
	function automatic logic [6:0] adcc_div_last(input logic [2:0] sel);
		logic [7:0] d;
		d = (8'h01 << sel) - 8'h01;
		if (sel == 3'h0) begin
			d = 8'h01;
		end
		return d[6:0];
	endfunction : adcc_div_last

endpackage : adcc_pkg

/* inc/adcc_core_if.sv */
`timescale 1ns/10ps
interface adcc_core_if;
	import adcc_pkg::*;
	logic [2:0] presc_sel;
	logic presc_run;
	logic tick;
	logic res_load;
	logic [RES_W-1:0] res_data;
	logic left_justify;
	logic rd_low;
	logic rd_high;
	logic res_taken;
	logic [7:0] low_byte;
	logic [7:0] high_byte;

	modport ctrl (output presc_sel, presc_run, res_load, res_data, left_justify, rd_low,
		rd_high, input tick, res_taken, low_byte, high_byte);
	modport presc (input presc_sel, presc_run, output tick);
	modport rlatch (input res_load, res_data, left_justify, rd_low, rd_high,
		output res_taken, low_byte, high_byte);
endinterface : adcc_core_if

/* verilog/adcc_prescaler.sv */
`timescale 1ns/10ps
module adcc_prescaler import adcc_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Control side
	adcc_core_if.presc bus
);

	logic [6:0] cnt;
	wire logic [6:0] last = adcc_div_last(bus.presc_sel);
	wire logic wrap = cnt >= last;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 7'h00;
		end else if (clk_en) begin
			if (!bus.presc_run || wrap) begin
				cnt <= 7'h00;
			end else begin
				cnt <= cnt + 7'h01;
			end
		end
	end

	assign bus.tick = bus.presc_run & wrap & clk_en;

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_PRESC_GAP: assert property (@(posedge pclk) disable iff (!presetn)
		bus.tick && bus.presc_sel == 3'h7 && $stable(bus.presc_sel) |=> !bus.tick [*8])
		else $error("converter clock tick came too early");

endmodule : adcc_prescaler

/* verilog/adcc_result_latch.sv */
`timescale 1ns/10ps
module adcc_result_latch import adcc_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Control side
	adcc_core_if.rlatch bus
);

	logic [RES_W-1:0] value;
	logic locked;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value <= '0;
			locked <= 1'b0;
		end else if (clk_en) begin
			if (bus.res_load && !locked) begin
				value <= bus.res_data;
			end
			if (bus.rd_high) begin
				locked <= 1'b0;
			end else if (bus.rd_low) begin
				locked <= 1'b1;
			end
		end
	end

	assign bus.res_taken = !locked;
	// Alignment follows the live bit, not the one at conversion time
	assign bus.low_byte = bus.left_justify ? {value[1:0], 6'h00} : value[7:0];
	assign bus.high_byte = bus.left_justify ? value[9:2] : {6'h00, value[9:8]};

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_LOCK_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		locked && !bus.rd_high |=> $stable(value))
		else $error("result changed while low byte read was pending");

endmodule : adcc_result_latch

/* verif/adcc_core_model.sv */
`timescale 1ns/10ps
module adcc_core_model import adcc_pkg::*; (
	// Clock
	input wire logic pclk,
	// Converter control
	input wire logic conv_busy,
	input wire adcc_src_t mux_src,
	input wire logic [2:0] mux_pos,
	input wire logic [2:0] mux_neg,
	input wire adcc_gain_t mux_gain,
	// Result
	output logic [RES_W-1:0] sar_result
);
	logic [RES_W-1:0] held;
	wire logic [RES_W-1:0] sel_code = {mux_src, mux_pos, mux_neg, mux_gain};

	// Result names the selection in use; outside a conversion no stale value is left
	assign sar_result = conv_busy ? sel_code : ~held;
	always_ff @(posedge pclk) begin
		if (conv_busy) begin
			held <= sel_code;
		end
	end
endmodule : adcc_core_model

/* verif/tb_adc_control_and_channel_select.sv */
`timescale 1ns/10ps
module tb_adc_control_and_channel_select import adcc_pkg::*;;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:1] trig_in;
	logic global_irq_en, irq_ack, irq, conv_busy, conv_init, err, lj;
	logic [RES_W-1:0] sar_result;
	adcc_src_t mux_src;
	adcc_gain_t mux_gain;
	logic [2:0] mux_pos, mux_neg;
	logic [15:0] seed, exp_pair;
	logic [4:0] code;
	logic [7:0] hold;
	int n_errors = 0, check_count = 0, cyc = 0, t0, n, i;

	adcc_top adcc_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .trig_in(trig_in), .global_irq_en(global_irq_en),
		.irq_ack(irq_ack), .irq(irq), .sar_result(sar_result), .conv_busy(conv_busy),
		.conv_init(conv_init), .mux_src(mux_src), .mux_pos(mux_pos), .mux_neg(mux_neg),
		.mux_gain(mux_gain));
	adcc_core_model adcc_core_model_inst (.pclk(pclk), .conv_busy(conv_busy),
		.mux_src(mux_src), .mux_pos(mux_pos), .mux_neg(mux_neg), .mux_gain(mux_gain),
		.sar_result(sar_result));

	// ****************************************************************
	// Reference model
	// ****************************************************************
	function automatic logic [9:0] exp_sel(input int c);
		int s, p, m, g;
		s = (c < 8) ? 0 : (c == 30) ? 2 : (c == 31) ? 3 : 1;
		p = (s > 1) ? 0 : (c > 7 && c < 16) ? (c & 4) / 2 + (c & 1) : c % 8;
		m = (s != 1) ? 0 : (c < 16) ? (c & 4) / 2 : (c < 24) ? 1 : 2;
		g = (s != 1 || c > 15) ? 0 : (c & 2) ? 2 : 1;
		return {s[1:0], p[2:0], m[2:0], g[1:0]};
	endfunction : exp_sel

	function automatic logic [15:0] pair(input logic [9:0] r, input logic l);
		return l ? {r, 6'h00} : {6'h00, r};
	endfunction : pair

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic stop_test();
		if (n_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic to_fail();
		n_errors++;
		stop_test();
	endtask : to_fail

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) to_fail();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wait_busy(input logic v);
		n = 0;
		while (conv_busy !== v) begin
			@(posedge pclk);
			n++;
			if (n > 4000) to_fail();
		end
	endtask : wait_busy

	task automatic chk_len(input int ticks, input int div);
		wait_busy(1'b0);
		n = cyc - t0;
		check_count++;
		if (n < (ticks - 1) * div - 1 || n > ticks * div + 2) begin
			n_errors++;
			$display("Error t=%0t got %h exp %h", $time, n, ticks * div);
		end
	endtask : chk_len

	// ****************************************************************
	// Stimulus
	// ****************************************************************
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always @(posedge pclk) cyc <= cyc + 1;

	initial begin
		{presetn, psel, penable, pwrite, global_irq_en, irq_ack} = '0;
		clk_en = 1'b1;
		paddr = '0;
		pwdata = '0;
		trig_in = '0;
		seed = 16'h4f70;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_CHAN, 8'h00);
		chk(rd, 32'h0);
		apb(1'b0, OFS_CTRL, 8'h00);
		chk(rd, 32'h0);
		chk({mux_src, mux_pos, mux_neg, mux_gain}, 32'h0);
		apb(1'b0, 8'h20, 8'h00);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		for (i = 0; i < 8; i++) begin
			apb(1'b1, OFS_CTRL, 8'hd0 | i[7:0]);
			t0 = cyc;
			chk(conv_init, 1'b1);
			chk_len(25, (i == 0) ? 2 : 1 << i);
			apb(1'b0, OFS_CTRL, 8'h00);
			chk(rd, 32'h90 | i);
			apb(1'b1, OFS_CTRL, 8'hd0 | i[7:0]);
			t0 = cyc;
			chk(conv_init, 1'b0);
			apb(1'b1, OFS_CTRL, 8'h80 | i[7:0]);
			chk(conv_busy, 1'b1);
			apb(1'b0, OFS_CTRL, 8'h00);
			chk(rd[6], 1'b1);
			chk_len(13, (i == 0) ? 2 : 1 << i);
			apb(1'b1, OFS_CTRL, i[7:0]);
			apb(1'b0, OFS_CTRL, 8'h00);
			chk(rd, 32'h10 | i);
		end
		apb(1'b1, OFS_CTRL, 8'hd0);
		repeat (5) @(posedge pclk);
		// Freeze: a 25-tick conversion must outlast 60 frozen cycles
		clk_en <= 1'b0;
		repeat (60) @(posedge pclk);
		chk(conv_busy, 1'b1);
		chk(pready, 1'b0);
		clk_en <= 1'b1;
		apb(1'b1, OFS_CTRL, 8'h00);
		chk(conv_busy, 1'b0);
		repeat (80) @(posedge pclk);
		apb(1'b0, OFS_CTRL, 8'h00);
		chk(rd, 32'h0);
		apb(1'b1, OFS_CTRL, 8'hc8);
		wait_busy(1'b0);
		@(posedge pclk);
		chk(irq, 1'b0);
		global_irq_en <= 1'b1;
		@(posedge pclk);
		chk(irq, 1'b1);
		irq_ack <= 1'b1;
		@(posedge pclk);
		irq_ack <= 1'b0;
		@(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b0, OFS_CTRL, 8'h00);
		chk(rd, 32'h88);
		for (i = 0; i < 32; i++) begin
			seed = lfsr(seed);
			code = seed[4:0];
			lj = seed[5];
			apb(1'b1, OFS_CHAN, i[7:0]);
			apb(1'b1, OFS_CTRL, 8'hd0);
			apb(1'b1, OFS_CHAN, {2'b00, lj, code});
			wait_busy(1'b0);
			exp_pair = pair(exp_sel(i), lj);
			apb(1'b0, OFS_RLO, 8'h00);
			chk(rd, exp_pair[7:0]);
			apb(1'b0, OFS_RHI, 8'h00);
			chk(rd, exp_pair[15:8]);
			chk({mux_src, mux_pos, mux_neg, mux_gain}, exp_sel(code));
			apb(1'b1, OFS_CHAN, {2'b00, ~lj, code});
			exp_pair = pair(exp_sel(i), ~lj);
			apb(1'b0, OFS_RHI, 8'h00);
			chk(rd, exp_pair[15:8]);
		end
		apb(1'b1, OFS_CHAN, 8'h07);
		apb(1'b0, OFS_RHI, 8'h00);
		hold = rd[7:0];
		apb(1'b0, OFS_RLO, 8'h00);
		apb(1'b1, OFS_CTRL, 8'hd0);
		wait_busy(1'b0);
		apb(1'b0, OFS_CTRL, 8'h00);
		chk(rd, 32'h80);
		apb(1'b0, OFS_RHI, 8'h00);
		chk(rd, hold);
		apb(1'b1, OFS_TRIG, 8'h60);
		apb(1'b1, OFS_CTRL, 8'hb0);
		trig_in <= 7'h04;
		repeat (3) @(posedge pclk);
		chk(conv_busy, 1'b1);
		wait_busy(1'b0);
		trig_in <= 7'h00;
		apb(1'b1, OFS_TRIG, 8'h00);
		repeat (4) @(posedge pclk);
		chk(conv_busy, 1'b0);
		apb(1'b1, OFS_CTRL, 8'he0);
		repeat (60) @(posedge pclk);
		apb(1'b0, OFS_CTRL, 8'h00);
		chk(rd, 32'hf0);
		apb(1'b1, OFS_CTRL, 8'h00);
		stop_test();
	end
endmodule : tb_adc_control_and_channel_select
